// File: verilog/smb_port.sv
// Serial microport with program loader: two-byte command/data transfers,
// control register, fill address, signature and program RAM.
// Assumes pins asynchronous to mclk and a serial clock well below mclk / 4.
`timescale 1ns/1ps
`include "smb_consts.svh"
module smb_port
    import smb_pkg::*;
#(
    parameter int DEPTH = `SMB_RAM_DEPTH,
    parameter int WIDTH = `SMB_RAM_WIDTH,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic             sclk_pin,
    input  wire logic             cs_n_pin,
    input  wire logic             primary_serial_line_in,
    output logic                  primary_serial_line_out,
    output logic                  primary_serial_line_oe,
    input  wire logic             secondary_input_line,
    output logic      [5:0]       device_register_addr,
    output logic      [7:0]       device_register_wdata,
    output logic                  device_register_wr,
    output logic                  device_register_rd,
    input  wire logic [7:0]       device_register_rdata,
    output logic                  load_enable_bit,
    output logic                  run_from_ram_bit,
    output logic      [7:0]       load_signature,
    input  wire logic [AW-1:0]    prog_fetch_addr,
    output logic      [WIDTH-1:0] prog_fetch_data
);
    localparam logic [AW:0] DEPTH_C = DEPTH[AW:0];

    // Synchronised pins
    logic [3:0]  pins_s;
    logic        sclk_s;
    logic        cs_n_s;
    logic        prim_s;
    logic        sec_s;

    // Edge history
    logic        sclk_d_reg;
    logic        cs_n_d_reg;

    // Transfer state
    smb_state_t  state_reg;
    smb_state_t  state_next;
    logic [4:0]  bit_cnt_reg;
    logic        lsb_mode_reg;
    logic [7:0]  rx_reg;
    logic        rw_reg;
    logic [5:0]  addr_reg;
    logic [7:0]  tx_reg;
    logic        tx_first_reg;
    logic [7:0]  ctrl_reg;
    logic [7:0]  misr_reg;
    logic [AW:0] fill_cnt_reg;

    // Decoded events
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        in_bit;
    logic [7:0]  rx_shift;
    logic        rx_take;
    logic        cmd_done;
    logic        data_done;
    logic        cmd_rw;
    logic [5:0]  cmd_addr;
    logic        cmd_ctrl;
    logic        is_ctrl;
    logic        load_on;
    logic        wr_commit;
    logic        ctrl_wr;
    logic        fill_wr;
    logic        dev_wr;
    logic        dev_rd;
    logic        fill_room;
    logic        ram_we;
    logic [7:0]  rd_val;
    logic [7:0]  tx_src;
    logic [7:0]  tx_shift;
    logic        tx_bit;
    logic [7:0]  misr_next;

    // Pin synchroniser, chip select idles high
    smb_sync #(
        .W       (4),
        .RST_VAL (`SMB_SYNC_RST)
    ) u_sync (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .async_in ({sclk_pin, cs_n_pin, primary_serial_line_in, secondary_input_line}),
        .sync_out (pins_s)
    );

    assign sclk_s = pins_s[3];
    assign cs_n_s = pins_s[2];
    assign prim_s = pins_s[1];
    assign sec_s  = pins_s[0];

    // Serial clock and select edges seen on mclk
    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s & sclk_d_reg;
    assign cs_fall   = ~cs_n_s & cs_n_d_reg;

    // Input line chosen by framing
    assign in_bit   = lsb_mode_reg ? prim_s : sec_s;
    assign rx_shift = lsb_mode_reg ? {in_bit, rx_reg[7:1]}
                                   : {rx_reg[6:0], in_bit};

    // Phase events; bits are taken on serial clock rises
    assign cmd_done  = sclk_rise & (state_reg == SMB_CMD)
                     & (bit_cnt_reg == `SMB_CMD_LAST);
    assign data_done = sclk_rise & (state_reg == SMB_DATA)
                     & (bit_cnt_reg == `SMB_XFER_LAST);
    assign rx_take   = sclk_rise & ((state_reg == SMB_CMD)
                     | ((state_reg == SMB_DATA) & ~(rw_reg & ~lsb_mode_reg)));

    // Command layout: first bit is read/write, next six the address
    assign cmd_rw   = lsb_mode_reg ? rx_shift[0] : rx_shift[7];
    assign cmd_addr = rx_shift[6:1];
    assign cmd_ctrl = (cmd_addr == `SMB_CTRL_ADDR);

    // Access decode
    assign load_on   = ctrl_reg[`SMB_LOAD_EN_BIT];
    assign is_ctrl   = (addr_reg == `SMB_CTRL_ADDR);
    assign wr_commit = data_done & ~rw_reg;
    assign ctrl_wr   = wr_commit & is_ctrl;
    assign fill_wr   = wr_commit & load_on & ~is_ctrl;
    assign dev_wr    = wr_commit & ~load_on & ~is_ctrl;
    assign dev_rd    = cmd_done & cmd_rw & ~load_on & ~cmd_ctrl;
    assign fill_room = (fill_cnt_reg < DEPTH_C);
    assign ram_we    = fill_wr & fill_room;

    // Read source for the data byte
    assign rd_val = is_ctrl ? ctrl_reg
                  : ~load_on ? device_register_rdata
                  : addr_reg[`SMB_ADDR_TOP_BIT] ? ctrl_reg
                  : misr_reg;

    // Outgoing bit order follows framing
    assign tx_src   = tx_first_reg ? rd_val : tx_reg;
    assign tx_bit   = lsb_mode_reg ? tx_src[0] : tx_src[7];
    assign tx_shift = lsb_mode_reg ? {1'b0, tx_src[7:1]} : {tx_src[6:0], 1'b0};

    // Signature register, feedback on the top bit
    assign misr_next = {misr_reg[6:0], 1'b0}
                     ^ (misr_reg[7] ? `SMB_MISR_POLY : 8'h00)
                     ^ rx_shift;

    // Transfer phase sequencing
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SMB_IDLE: begin
                if (cs_fall) begin
                    state_next = SMB_CMD;
                end
            end
            SMB_CMD: begin
                if (cs_n_s) begin
                    state_next = SMB_IDLE;
                end else if (cmd_done) begin
                    state_next = SMB_DATA;
                end
            end
            SMB_DATA: begin
                if (cs_n_s) begin
                    state_next = SMB_IDLE;
                end else if (data_done) begin
                    state_next = SMB_DONE;
                end
            end
            SMB_DONE: begin
                if (cs_n_s) begin
                    state_next = SMB_IDLE;
                end
            end
            default: begin
                state_next = SMB_IDLE;
            end
        endcase
    end

    // Edge history and phase register
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_d_reg <= 1'b0;
            cs_n_d_reg <= 1'b1;
            state_reg  <= SMB_IDLE;
        end else if (clk_en) begin
            sclk_d_reg <= sclk_s;
            cs_n_d_reg <= cs_n_s;
            state_reg  <= state_next;
        end
    end

    // Framing caught from the clock level at select fall
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lsb_mode_reg <= 1'b0;
        end else if (clk_en && cs_fall) begin
            lsb_mode_reg <= sclk_s;
        end
    end

    // Bit counter over the two bytes
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bit_cnt_reg <= 5'h00;
        end else if (clk_en) begin
            if (cs_fall) begin
                bit_cnt_reg <= 5'h00;
            end else if (sclk_rise && (state_reg == SMB_CMD || state_reg == SMB_DATA)) begin
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
        end
    end

    // Receive shifter and latched command
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_reg   <= 8'h00;
            rw_reg   <= 1'b0;
            addr_reg <= 6'h00;
        end else if (clk_en) begin
            if (rx_take) begin
                rx_reg <= rx_shift;
            end
            if (cmd_done) begin
                rw_reg   <= cmd_rw;
                addr_reg <= cmd_addr;
            end
        end
    end

    // Transmit shifter, changes on serial clock falls
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_reg                  <= 8'h00;
            tx_first_reg            <= 1'b0;
            primary_serial_line_out <= 1'b0;
        end else if (clk_en) begin
            if (cmd_done) begin
                tx_first_reg <= 1'b1;
            end else if (sclk_fall && state_reg == SMB_DATA) begin
                tx_first_reg            <= 1'b0;
                tx_reg                  <= tx_shift;
                primary_serial_line_out <= tx_bit;
            end
        end
    end

    // Primary line drive: whole frame when MSB-first, read data when LSB-first
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            primary_serial_line_oe <= 1'b0;
        end else if (clk_en) begin
            if (cs_n_s) begin
                primary_serial_line_oe <= 1'b0;
            end else if (!lsb_mode_reg && state_reg != SMB_IDLE) begin
                primary_serial_line_oe <= 1'b1;
            end else if (lsb_mode_reg && sclk_fall && state_reg == SMB_DATA && rw_reg) begin
                primary_serial_line_oe <= 1'b1;
            end
        end
    end

    // Control register at its fixed address
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_reg <= `SMB_CTRL_RST;
        end else if (clk_en && ctrl_wr) begin
            ctrl_reg <= rx_shift;
        end
    end

    // Fill address and signature, reseeded whenever loading is off
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fill_cnt_reg <= '0;
            misr_reg     <= `SMB_MISR_SEED;
        end else if (clk_en) begin
            if (!load_on) begin
                fill_cnt_reg <= '0;
                misr_reg     <= `SMB_MISR_SEED;
            end else if (ram_we) begin
                fill_cnt_reg <= fill_cnt_reg + 1'b1;
                misr_reg     <= misr_next;
            end
        end
    end

    // Device register strobes and data
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            device_register_addr  <= 6'h00;
            device_register_wdata <= 8'h00;
            device_register_wr    <= 1'b0;
            device_register_rd    <= 1'b0;
        end else if (clk_en) begin
            device_register_wr <= dev_wr;
            device_register_rd <= dev_rd;
            if (cmd_done) begin
                device_register_addr <= cmd_addr;
            end
            if (dev_wr) begin
                device_register_wdata <= rx_shift;
            end
        end
    end

    // Mode and signature outputs
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            load_enable_bit  <= 1'b0;
            run_from_ram_bit <= 1'b0;
            load_signature   <= `SMB_MISR_SEED;
        end else if (clk_en) begin
            load_enable_bit  <= load_on;
            run_from_ram_bit <= ctrl_reg[`SMB_RUN_RAM_BIT];
            load_signature   <= misr_reg;
        end
    end

    // Program storage filled at the internal address
    smb_prog_ram #(
        .DEPTH (DEPTH),
        .WIDTH (WIDTH),
        .AW    (AW)
    ) u_ram (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .wr_en   (ram_we),
        .wr_addr (fill_cnt_reg[AW-1:0]),
        .wr_data (rx_shift[WIDTH-1:0]),
        .rd_addr (prog_fetch_addr),
        .rd_data (prog_fetch_data)
    );
endmodule

// File: include/smb_consts.svh
// Constants of the serial microport and program loader: offsets, fields, resets.
// Assumes inclusion by bare name from design files that also import smb_pkg.
//
// What this block does
// - Clock high at select fall: LSB-first, shared line
// - Clock low at select fall: MSB-first, separate lines
// - MSB-first is full duplex, idle-low clock
// - Input line ignored during MSB-first reads
// - First eight clocks carry command/address byte
// - Next eight clocks carry the data byte
// - Select rising releases primary line while high
// - Data bit order follows detected framing
// - Command byte layout differs per framing
// - Sample on clock rise, change on fall
// - Load-enable bit at 0x3f enters/leaves loading
// - Loading writes fill RAM at internal address
// - Reads leave the fill address unchanged
// - Only first 4096 fill writes are stored
// - 8-bit signature register absorbs fill data only
// - Write to 0x3f touches control only
// - Loading read, top address bit set: control
// - Loading read, top address bit clear: signature
// - Outside loading, accesses other than 0x3f reach device registers
// - Clearing load enable reseeds signature, fill address
`ifndef SMB_CONSTS_SVH
`define SMB_CONSTS_SVH

`define SMB_CTRL_ADDR       6'h3f
`define SMB_ADDR_TOP_BIT    5
`define SMB_LOAD_EN_BIT     2
`define SMB_RUN_RAM_BIT     3
`define SMB_CTRL_RST        8'h00
`define SMB_MISR_SEED       8'h00
`define SMB_MISR_POLY       8'h1d
`define SMB_RAM_DEPTH       4096
`define SMB_RAM_WIDTH       8
`define SMB_CMD_LAST        5'h07
`define SMB_XFER_LAST       5'h0f
`define SMB_SYNC_RST        4'h4

`endif

// File: include/smb_pkg.sv
// Types shared by the serial microport and program loader.
// Assumes nothing beyond a SystemVerilog compiler.
package smb_pkg;

    // Transfer phases, Gray coded along idle, command, data, done
    typedef enum logic [1:0] {
        SMB_IDLE = 2'b00,
        SMB_CMD  = 2'b01,
        SMB_DATA = 2'b11,
        SMB_DONE = 2'b10
    } smb_state_t;

endpackage

// File: verilog/smb_sync.sv
// Two-flop synchroniser for pins arriving from outside the mclk domain.
// Assumes mclk is several times faster than any pin change of interest.
`timescale 1ns/1ps
module smb_sync #(
    parameter int              W       = 4,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    input  wire logic          mclk,
    input  wire logic          sys_rst,
    input  wire logic          clk_en,
    input  wire logic [W-1:0]  async_in,
    output logic      [W-1:0]  sync_out
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= RST_VAL;
            sync_out <= RST_VAL;
        end else if (clk_en) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// File: verilog/smb_prog_ram.sv
// Write-port program RAM built from flip-flops, with a registered fetch port.
// Assumes one write per cycle at most and a fetch address on mclk.
`timescale 1ns/1ps
module smb_prog_ram #(
    parameter int DEPTH = 4096,
    parameter int WIDTH = 8,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             clk_en,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // One storage word per entry, written when its index matches
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_word
            always_ff @(posedge mclk) begin
                if (clk_en && wr_en && (wr_addr == AW'(gi))) begin
                    mem[gi] <= wr_data;
                end
            end
        end
    endgenerate

    // Registered fetch port for program execution
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data <= '0;
        end else if (clk_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// File: dv/smb_port_props.sv
// Checker for the serial port and loader, watching top-level ports only.
// Assumes a single mclk domain and sys_rst as its asynchronous reset.
`timescale 1ns/1ps
module smb_port_props (
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       sclk_pin,
    input wire logic       cs_n_pin,
    input wire logic       primary_serial_line_out,
    input wire logic       primary_serial_line_oe,
    input wire logic [5:0] device_register_addr,
    input wire logic       device_register_wr,
    input wire logic       device_register_rd,
    input wire logic       load_enable_bit,
    input wire logic       run_from_ram_bit,
    input wire logic [7:0] load_signature
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // Select high long enough to pass the synchroniser
    sequence s_cs_idle;
        cs_n_pin [*6];
    endsequence
    // Output bit moving while the line stays driven in a frame
    sequence s_out_move;
        primary_serial_line_oe && $past(primary_serial_line_oe) && !cs_n_pin
            && $changed(primary_serial_line_out);
    endsequence

    AST_OE_RELEASE: assert property (s_cs_idle |-> !primary_serial_line_oe)
        else $error("primary line driven while select high");
    AST_OE_SELECTED: assert property ($rose(primary_serial_line_oe) |-> !cs_n_pin && !$past(cs_n_pin, 2))
        else $error("primary line driven without a select fall");
    AST_OUT_ON_FALL: assert property (s_out_move |-> !$past(sclk_pin, 2))
        else $error("output bit changed away from a clock fall");
    AST_WR_ROUTE: assert property (device_register_wr |-> !load_enable_bit && device_register_addr != 6'h3f)
        else $error("device write during loading or to control");
    AST_RD_ROUTE: assert property (device_register_rd |-> !load_enable_bit && device_register_addr != 6'h3f)
        else $error("device read during loading or to control");
    AST_WR_PULSE: assert property (device_register_wr |-> !cs_n_pin ##1 !device_register_wr)
        else $error("device write outside a frame or too long");
    AST_RD_AFTER_CMD: assert property (device_register_rd |-> !cs_n_pin && $past(sclk_pin, 2))
        else $error("device read not after a command byte");
    AST_MISR_SEED: assert property (!load_enable_bit [*3] |-> load_signature == 8'h00)
        else $error("signature not at seed outside loading");
    AST_MISR_FILL: assert property ($changed(load_signature) && load_signature != 8'h00 |-> load_enable_bit && !cs_n_pin)
        else $error("signature moved outside a fill write");
    AST_CTRL_IN_FRAME: assert property ($changed(load_enable_bit) || $changed(run_from_ram_bit) |-> !cs_n_pin)
        else $error("control bits moved outside a frame");
endmodule

bind smb_port smb_port_props i_props (
    .mclk, .sys_rst, .sclk_pin, .cs_n_pin, .primary_serial_line_out,
    .primary_serial_line_oe, .device_register_addr, .device_register_wr,
    .device_register_rd, .load_enable_bit, .run_from_ram_bit, .load_signature
);

// File: dv/smb_host_model.sv
// Host model: a small controller with a synchronous serial port.
// Assumes mclk as timebase; each serial clock phase spans four mclk cycles.
`timescale 1ns/1ps
module smb_host_model (
    input  wire logic mclk,
    input  wire logic line_in,
    output logic      line_drv,
    output logic      sclk_pin,
    output logic      cs_n_pin,
    output logic      secondary_input_line
);
    logic p_drv = 1'b0;
    logic s_drv = 1'b0;
    logic bit_val = 1'b0;
    logic junk = 1'b0;

    // Idle link: select high, clock low
    initial begin
        sclk_pin = 1'b0;
        cs_n_pin = 1'b1;
    end
    // Released lines toggle so a stale level never reads as data
    always @(posedge mclk) junk <= ~junk;
    assign line_drv = p_drv ? bit_val : junk;
    assign secondary_input_line = s_drv ? bit_val : junk;

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // One two-byte transfer; lsb picks the framing
    task automatic xfer(input logic lsb, input logic rw, input logic [5:0] a,
                        input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] s;
        s = 16'h0000;
        rd = 8'h00;
        s[0] = rw;
        for (int i = 0; i < 6; i++) s[1 + i] = lsb ? a[i] : a[5 - i];
        for (int i = 0; i < 8; i++) s[8 + i] = lsb ? wd[i] : wd[7 - i];
        sclk_pin = lsb;
        step(4);
        cs_n_pin = 1'b0;
        step(4);
        for (int i = 0; i < 16; i++) begin
            sclk_pin = 1'b0;
            bit_val = s[i];
            p_drv = lsb && !(rw && i > 7);
            s_drv = !lsb && !(rw && i > 7);
            step(4);
            sclk_pin = 1'b1;
            if (rw && i > 7) rd[lsb ? i - 8 : 15 - i] = line_in;
            step(4);
        end
        p_drv = 1'b0;
        s_drv = 1'b0;
        sclk_pin = lsb;
        step(4);
        cs_n_pin = 1'b1;
        step(4);
    endtask
endmodule

// File: dv/serial_microport_bootloader_tb.sv
// Testbench for the serial port and loader: register, fill and framing runs.
// Assumes the host model drives the link and a device-register stub here.
`timescale 1ns/1ps
module serial_microport_bootloader_tb;
    localparam int DEPTH = 16;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        line, host_line, sclk, cs_n, sec_line;
    logic        line_out, line_oe, dr_wr, dr_rd, le, rr;
    logic [5:0]  dr_addr;
    logic [7:0]  dr_wdata, misr_val, fetch_data, rd, d, exp_misr;
    logic        clk_en = 1'b1;
    logic [7:0]  dr_rdata = 8'h00;
    logic [7:0]  wr_cnt = 8'h00;
    logic [7:0]  rd_cnt = 8'h00;
    logic [13:0] wr_last = 14'h0000;
    logic [3:0]  fetch_addr = 4'h0;
    logic [7:0]  mem [DEPTH];
    int          bad_count = 0;
    int          total_checks = 0;

    always #5 mclk = ~mclk;
    // Shared primary line: device wins while enabled
    assign line = line_oe ? line_out : host_line;

    // Device-register stub: answers reads, records writes
    always @(posedge mclk) begin
        if (dr_rd) begin
            dr_rdata <= #1 {2'b10, dr_addr};
            rd_cnt   <= #1 rd_cnt + 8'h01;
        end
        if (dr_wr) begin
            wr_last <= #1 {dr_addr, dr_wdata};
            wr_cnt  <= #1 wr_cnt + 8'h01;
        end
    end

    smb_port #(.DEPTH(DEPTH)) i_dut (
        .mclk                    (mclk),
        .sys_rst                 (sys_rst),
        .clk_en                  (clk_en),
        .sclk_pin                (sclk),
        .cs_n_pin                (cs_n),
        .primary_serial_line_in  (line),
        .primary_serial_line_out (line_out),
        .primary_serial_line_oe  (line_oe),
        .secondary_input_line    (sec_line),
        .device_register_addr    (dr_addr),
        .device_register_wdata   (dr_wdata),
        .device_register_wr      (dr_wr),
        .device_register_rd      (dr_rd),
        .device_register_rdata   (dr_rdata),
        .load_enable_bit         (le),
        .run_from_ram_bit        (rr),
        .load_signature          (misr_val),
        .prog_fetch_addr         (fetch_addr),
        .prog_fetch_data         (fetch_data)
    );

    smb_host_model i_host (
        .mclk                 (mclk),
        .line_in              (line),
        .line_drv             (host_line),
        .sclk_pin             (sclk),
        .cs_n_pin             (cs_n),
        .secondary_input_line (sec_line)
    );

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] misr_step(input logic [7:0] s, input logic [7:0] v);
        return {s[6:0], 1'b0} ^ (s[7] ? 8'h1d : 8'h00) ^ v;
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog: about ten times the expected run length
    initial begin
        #500000;
        bad_count++;
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge mclk);
        #1 sys_rst = 1'b0;
        step(4);
        check({le, rr, line_oe, misr_val}, 16'h0000);
        for (int m = 0; m < 2; m++) begin
            i_host.xfer(m == 1, 1'b0, 6'h14 + 6'(m), 8'ha2 + 8'(m), rd);
            check(wr_last, {6'h14 + 6'(m), 8'ha2 + 8'(m)});
            i_host.xfer(m == 1, 1'b1, 6'h2a, 8'h00, rd);
            check(rd, 8'haa);
            i_host.xfer(m == 1, 1'b1, 6'h3f, 8'h00, rd);
            check(rd, 8'h00);
        end
        check({wr_cnt, rd_cnt}, 16'h0202);
        i_host.xfer(1'b0, 1'b0, 6'h3f, 8'h04, rd);
        check({rr, le}, 2'b01);
        exp_misr = 8'h00;
        // Fill past the RAM depth, framing alternating
        for (int i = 0; i < DEPTH + 2; i++) begin
            d = 8'h30 + 8'(i * 7);
            i_host.xfer(i[0], 1'b0, 6'(i * 3), d, rd);
            if (i < DEPTH) begin
                exp_misr = misr_step(exp_misr, d);
                mem[i] = d;
            end
            if (i == 3) begin
                i_host.xfer(1'b1, 1'b1, 6'h05, 8'h00, rd);
                check(rd, exp_misr);
                i_host.xfer(1'b0, 1'b0, 6'h3f, 8'h04, rd);
                i_host.xfer(1'b1, 1'b1, 6'h25, 8'h00, rd);
                check(rd, 8'h04);
            end
        end
        check(misr_val, exp_misr);
        check({wr_cnt, rd_cnt}, 16'h0202);
        for (int i = 0; i < DEPTH; i++) begin
            fetch_addr = 4'(i);
            step(2);
            check(fetch_data, mem[i]);
        end
        i_host.xfer(1'b1, 1'b0, 6'h3f, 8'h08, rd);
        check({rr, le, misr_val}, 10'h200);
        i_host.xfer(1'b0, 1'b1, 6'h05, 8'h00, rd);
        check(rd, 8'h85);
        i_host.xfer(1'b0, 1'b0, 6'h3f, 8'h04, rd);
        i_host.xfer(1'b1, 1'b0, 6'h11, 8'hc6, rd);
        fetch_addr = 4'h0;
        step(2);
        check({fetch_data, misr_val}, {8'hc6, misr_step(8'h00, 8'hc6)});
        // Frozen clock enable: a control write while stalled must not land
        clk_en = 1'b0;
        i_host.xfer(1'b1, 1'b0, 6'h3f, 8'h00, rd);
        clk_en = 1'b1;
        step(4);
        check({rr, le, misr_val}, {2'b01, misr_step(8'h00, 8'hc6)});
        complete_run();
    end
endmodule
